// [reset_and_watchdog_config_map.svh]
// register indices, field positions and reset values of the config block
`ifndef RESET_AND_WATCHDOG_CONFIG_MAP_SVH
`define RESET_AND_WATCHDOG_CONFIG_MAP_SVH

// register indices; byte address is four times the index
`define RWC_IDX_CONTROL      24'h300000
`define RWC_IDX_STATUS       24'h300001
`define RWC_IDX_SUPERVISION  24'h300002
`define RWC_IDX_WATCHDOG     24'h300003

// implemented bits of the two configuration bytes
`define RWC_SUP_MASK         8'h0F
`define RWC_WDG_MASK         8'h1F
`define RWC_UNPROGRAMMED     8'hFF

// low byte fields
`define RWC_BOR_SEL_LSB      2
`define RWC_BOR_EN_BIT       1
`define RWC_POWERUP_DELAY_TIMER_N_BIT       0
// high byte fields
`define RWC_WDPS_LSB         1
`define RWC_WDG_HARD_BIT     0

// control register fields
`define RWC_CTL_SOFT_BIT     0
`define RWC_CTL_ERASE_BIT    1
`define RWC_CTL_RESET        1'h0

// postscale ratio that goes with the unprogrammed select 1111
`define RWC_RATIO_RESET      16'h8000

`endif

// [reset_and_watchdog_config_pkg.sv]
// types shared by the configuration block
package reset_and_watchdog_config_pkg;
    typedef logic [7:0] cfg_byte_t;
    typedef logic [1:0] cell_sel_t;
    typedef enum logic [1:0] {
        BOR_THR_SEL_0   = 2'h0,
        BOR_THR_SEL_1   = 2'h1,
        BOR_THR_SEL_2   = 2'h2,
        BOR_THR_2V0     = 2'h3
    } bor_threshold_e;
endpackage

// [config_cell_array.sv]
// nonvolatile configuration cells: programming only clears bits
`timescale 1ns/1ps
`default_nettype none
`include "reset_and_watchdog_config_map.svh"
module config_cell_array #(
    parameter int NUM_CELLS = 2
) (
    input  wire logic                         pclk,      // clock
    input  wire logic                         por_n,     // power-on
    input  wire logic                         prog_en,   // program
    input  wire logic                         erase,     // bulk erase
    input  wire logic [$clog2(NUM_CELLS)-1:0] prog_sel,  // cell
    input  wire logic [7:0]                   prog_data, // new bits
    input  wire logic [7:0]                   cell_mask [NUM_CELLS], // used
    output var  logic [7:0]                   cell_q [NUM_CELLS] // stored
);
    // =====================================================================
    // cells
    // only power-on or an explicit erase returns a bit to one
    always_ff @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            for (int i = 0; i < NUM_CELLS; i++) begin
                cell_q[i] <= `RWC_UNPROGRAMMED;
            end
        end else if (erase) begin
            for (int i = 0; i < NUM_CELLS; i++) begin
                cell_q[i] <= `RWC_UNPROGRAMMED;
            end
        end else if (prog_en) begin
            cell_q[prog_sel] <= cell_q[prog_sel] & prog_data;
        end
    end

    // an implemented bit programmed to zero must read zero afterwards
    a_mask_kept: assert property (@(posedge pclk) disable iff (!por_n)
        prog_en && !erase |=> ((cell_q[$past(prog_sel)]
            & ~$past(prog_data) & cell_mask[$past(prog_sel)]) == 8'h00))
        else $error("programming left a cleared bit set");
endmodule // config_cell_array
`default_nettype wire

// [reset_and_watchdog_config.sv]
// reset supervision and watchdog configuration with apb access
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "reset_and_watchdog_config_map.svh"
module reset_and_watchdog_config #(
    parameter int ADDR_W = 32
) (
    input  wire logic              pclk,                  // apb clock
    input  wire logic              presetn,               // device reset
    input  wire logic              por_n,                 // power-on reset
    input  wire logic              psel,                  // apb select
    input  wire logic              penable,               // apb enable
    input  wire logic              pwrite,                // apb direction
    input  wire logic [ADDR_W-1:0] paddr,                 // apb address
    input  wire logic [31:0]       pwdata,                // apb write data
    output logic                   pready,                // apb ready
    output logic [31:0]            prdata,                // apb read data
    output logic                   pslverr,               // apb error
    output logic [1:0]             brownout_threshold_select, // latched
    output logic                   brownout_reset_enable, // latched
    output logic                   powerup_delay_enable_n, // latched
    output logic [3:0]             watchdog_postscale_sel, // latched
    output logic [15:0]            watchdog_postscale_ratio, // divide ratio
    output logic                   watchdog_run           // watchdog on
);
    // =====================================================================
    // address decode
    function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
        logic [23:0] idx;
        idx = a[25:2];
        decode = 3'h0;
        if (a[1:0] == 2'h0 && (ADDR_W <= 26 || a[ADDR_W-1:26] == '0)) begin
            case (idx)
                `RWC_IDX_CONTROL:     decode = 3'h1;
                `RWC_IDX_STATUS:      decode = 3'h2;
                `RWC_IDX_SUPERVISION: decode = 3'h3;
                `RWC_IDX_WATCHDOG:    decode = 3'h4;
                default:              decode = 3'h0;
            endcase
        end
    endfunction

    logic [2:0] sel_reg;
    logic       setup_ph;
    logic       access_ph;
    assign sel_reg   = decode(paddr);
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    // tied high: every access ends in its first access cycle
    assign pready    = 1'b1;

    // =====================================================================
    // configuration cells
    reset_and_watchdog_config_pkg::cfg_byte_t cell_q [2];
    reset_and_watchdog_config_pkg::cfg_byte_t cell_mask [2];
    reset_and_watchdog_config_pkg::cfg_byte_t sup_rd;
    reset_and_watchdog_config_pkg::cfg_byte_t wdg_rd;
    logic prog_en;
    logic erase;
    reset_and_watchdog_config_pkg::cell_sel_t prog_sel2;

    assign cell_mask[0] = `RWC_SUP_MASK;
    assign cell_mask[1] = `RWC_WDG_MASK;
    assign sup_rd = cell_q[0] & `RWC_SUP_MASK;
    assign wdg_rd = cell_q[1] & `RWC_WDG_MASK;
    assign prog_en = access_ph && pwrite &&
                     (sel_reg == 3'h3 || sel_reg == 3'h4);
    assign prog_sel2 = (sel_reg == 3'h4) ? 2'h1 : 2'h0;
    assign erase = access_ph && pwrite && sel_reg == 3'h1 &&
                   pwdata[`RWC_CTL_ERASE_BIT];

    config_cell_array #(
        .NUM_CELLS (2)
    ) u_cells (
        .pclk      (pclk),
        .por_n     (por_n),
        .prog_en   (prog_en),
        .erase     (erase),
        .prog_sel  (prog_sel2[0]),
        .prog_data (pwdata[7:0]),
        .cell_mask (cell_mask),
        .cell_q    (cell_q)
    );

    // =====================================================================
    // software watchdog enable
    logic soft_en_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_en_q <= `RWC_CTL_RESET;
        end else if (access_ph && pwrite && sel_reg == 3'h1) begin
            soft_en_q <= pwdata[`RWC_CTL_SOFT_BIT];
        end
    end

    // =====================================================================
    // capture at reset release; held until the next reset
    // a later programming changes only the cells, not the live settings
    logic                        loaded_q;
    reset_and_watchdog_config_pkg::cfg_byte_t sup_q;
    reset_and_watchdog_config_pkg::cfg_byte_t wdg_q;
    logic [15:0]                 ratio_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_q <= 1'b0;
            sup_q    <= `RWC_UNPROGRAMMED & `RWC_SUP_MASK;
            wdg_q    <= `RWC_UNPROGRAMMED & `RWC_WDG_MASK;
            ratio_q  <= `RWC_RATIO_RESET;
        end else if (!loaded_q) begin
            loaded_q <= 1'b1;
            sup_q    <= sup_rd;
            wdg_q    <= wdg_rd;
            ratio_q  <= 16'h0001 << wdg_rd[`RWC_WDPS_LSB +: 4];
        end
    end

    // =====================================================================
    // field decode
    assign brownout_threshold_select =
        sup_q[`RWC_BOR_SEL_LSB +: 2];
    assign brownout_reset_enable  = sup_q[`RWC_BOR_EN_BIT];
    assign powerup_delay_enable_n = sup_q[`RWC_POWERUP_DELAY_TIMER_N_BIT];
    assign watchdog_postscale_sel = wdg_q[`RWC_WDPS_LSB +: 4];
    // the ratio is captured beside the select so both move on one edge
    assign watchdog_postscale_ratio = ratio_q;

    logic run_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else begin
            run_q <= wdg_q[`RWC_WDG_HARD_BIT] || soft_en_q;
        end
    end
    assign watchdog_run = run_q;

    // =====================================================================
    // read data, registered in the setup phase
    logic [15:0] status_w;
    assign status_w = {4'h0, loaded_q, run_q, soft_en_q,
                       wdg_q[`RWC_WDG_HARD_BIT], watchdog_postscale_sel,
                       powerup_delay_enable_n, brownout_reset_enable,
                       brownout_threshold_select};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            pslverr <= (sel_reg == 3'h0);
            case (sel_reg)
                3'h1:    prdata <= {31'h00000000, soft_en_q};
                3'h2:    prdata <= {16'h0000, status_w};
                3'h3:    prdata <= {24'h000000, sup_rd};
                3'h4:    prdata <= {24'h000000, wdg_rd};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_bor_thr_map: assert property ($rose(loaded_q) |->
        brownout_threshold_select == $past(sup_rd[3:2]))
        else $error("threshold select not from bits 3..2");
    a_bor_en_map: assert property ($rose(loaded_q) |->
        brownout_reset_enable == $past(sup_rd[1]))
        else $error("brown-out enable not taken from bit 1");
    a_powerup_delay_timer_map: assert property ($rose(loaded_q) |->
        powerup_delay_enable_n == $past(sup_rd[0]))
        else $error("power-up enable not taken from bit 0");
    a_indep_fields: assert property ($rose(loaded_q) |->
        {brownout_reset_enable, powerup_delay_enable_n}
        == $past(sup_rd[1:0]))
        else $error("bor and powerup_delay_timer fields coupled");
    // a read of either cell shows at most its implemented bits
    a_upper_zero: assert property (setup_ph && (sel_reg == 3'h3 ||
        sel_reg == 3'h4) |=> prdata[31:5] == 27'h0 &&
        (prdata[4] == 1'b0 || $past(sel_reg) == 3'h4))
        else $error("unimplemented bits read nonzero");
    a_prog_clears: assert property (prog_en && !erase |=>
        (cell_q[$past(prog_sel2[0])] & ~$past(cell_q[prog_sel2[0]]))
        == 8'h00)
        else $error("programming set a cell bit");
    // exactly one ratio bit, and it is the one the select points at
    a_ratio_pow2: assert property ($onehot(watchdog_postscale_ratio) &&
        watchdog_postscale_ratio[watchdog_postscale_sel])
        else $error("postscale ratio wrong");
    a_hard_run: assert property (loaded_q && wdg_q[0] |=>
        watchdog_run)
        else $error("watchdog not forced on");
    a_soft_run: assert property (loaded_q && !wdg_q[0] && !soft_en_q
        ##1 !soft_en_q |=> !watchdog_run)
        else $error("watchdog runs without enable");
    a_held_stable: assert property (loaded_q ##1 loaded_q |->
        $stable(sup_q) && $stable(wdg_q) && $stable(ratio_q))
        else $error("settings changed between resets");
    a_unmapped_err: assert property (setup_ph && sel_reg == 3'h0 |=>
        pslverr && prdata == 32'h0)
        else $error("unmapped access not flagged");

    c_program_low: cover property (prog_en && sel_reg == 3'h3);
    c_program_high: cover property (prog_en && sel_reg == 3'h4);
    c_soft_on: cover property (!wdg_q[0] && soft_en_q ##1 watchdog_run);
    c_erase: cover property (erase);
    c_thr_2v0: cover property (loaded_q && brownout_threshold_select ==
        reset_and_watchdog_config_pkg::BOR_THR_2V0);
endmodule // reset_and_watchdog_config
`default_nettype wire

// [programmer_model.sv]
// apb master standing in for the configuration programmer
`timescale 1ns/1ps
`default_nettype none
module programmer_model (
    input  wire logic        pclk,    // bus clock
    input  wire logic        pready,  // slave ready
    input  wire logic [31:0] prdata,  // read data
    input  wire logic        pslverr, // slave error
    output var  logic        psel,    // select
    output var  logic        penable, // enable
    output var  logic        pwrite,  // direction
    output var  logic [31:0] paddr,   // byte address
    output var  logic [31:0] pwdata   // write data
);
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end
    // ==================================================================
    // one transfer; it opens after an edge so calls never collide
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e, output logic hung);
        int n;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 64);
        hung = (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        // released lines carry garbage, not the last request
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule // programmer_model
`default_nettype wire

// [testbench.sv]
// self-checking bench for the reset and watchdog configuration block
`timescale 1ns/1ps
`default_nettype none
`include "reset_and_watchdog_config_map.svh"
`define CHK(nm, ex, got) begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
        err_total++; \
        $display("BAD %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module testbench;
    typedef struct packed {
        logic [7:0]  lo;    // programmed low byte
        logic [7:0]  hi;    // programmed high byte
        logic [7:0]  live;  // {sel, powerup_delay_timer_n, bor, thr} after reset
        logic [15:0] ratio; // divide ratio after reset
        logic        run;   // watchdog state with soft enable off
    } row_s;
    localparam logic [31:0] A_CTL = 32'(`RWC_IDX_CONTROL) << 2;
    localparam logic [31:0] A_STS = 32'(`RWC_IDX_STATUS) << 2;
    localparam logic [31:0] A_SUP = 32'(`RWC_IDX_SUPERVISION) << 2;
    localparam logic [31:0] A_WDG = 32'(`RWC_IDX_WATCHDOG) << 2;
    logic        pclk, presetn, por_n, psel, penable, pwrite;
    logic        pready, pslverr, brownout_reset_enable;
    logic        powerup_delay_enable_n, watchdog_run;
    logic [31:0] paddr, pwdata, prdata;
    logic [1:0]  brownout_threshold_select;
    logic [3:0]  watchdog_postscale_sel;
    logic [15:0] watchdog_postscale_ratio;
    int          err_total, comparisons;
    row_s rows [16] = '{
        '{8'hF0, 8'hFE, 8'hF0, 16'h8000, 1'h0},
        '{8'hF1, 8'hFC, 8'hE8, 16'h4000, 1'h0},
        '{8'hF2, 8'hFA, 8'hD4, 16'h2000, 1'h0},
        '{8'hF3, 8'hF8, 8'hCC, 16'h1000, 1'h0},
        '{8'hF4, 8'hF7, 8'hB1, 16'h0800, 1'h1},
        '{8'hF5, 8'hF5, 8'hA9, 16'h0400, 1'h1},
        '{8'hF6, 8'hF3, 8'h95, 16'h0200, 1'h1},
        '{8'hF7, 8'hF1, 8'h8D, 16'h0100, 1'h1},
        '{8'hF8, 8'hEE, 8'h72, 16'h0080, 1'h0},
        '{8'hF9, 8'hEC, 8'h6A, 16'h0040, 1'h0},
        '{8'hFA, 8'hEA, 8'h56, 16'h0020, 1'h0},
        '{8'hFB, 8'hE8, 8'h4E, 16'h0010, 1'h0},
        '{8'hFC, 8'hE7, 8'h33, 16'h0008, 1'h1},
        '{8'hFD, 8'hE5, 8'h2B, 16'h0004, 1'h1},
        '{8'hFE, 8'hE3, 8'h17, 16'h0002, 1'h1},
        '{8'hFF, 8'hE1, 8'h0F, 16'h0001, 1'h1}};
    reset_and_watchdog_config dut_u (.pclk(pclk), .presetn(presetn),
        .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr),
        .brownout_threshold_select(brownout_threshold_select),
        .brownout_reset_enable(brownout_reset_enable),
        .powerup_delay_enable_n(powerup_delay_enable_n),
        .watchdog_postscale_sel(watchdog_postscale_sel),
        .watchdog_postscale_ratio(watchdog_postscale_ratio),
        .watchdog_run(watchdog_run));
    programmer_model prog_u (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    // ==================================================================
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        logic hung;
        prog_u.xfer(w, a, d, q, e, hung);
        if (hung) begin
            err_total++;
            $display("BAD pready expected 1 seen 0");
            give_verdict();
        end
    endtask
    task automatic rdchk(input string nm, input logic [31:0] a,
                         input logic [31:0] ex);
        logic [31:0] q;
        logic        e;
        bus(1'h0, a, 32'h0, q, e);
        `CHK(nm, ex, q)
    endtask
    // settings load on the first edge after release, run one edge later
    task automatic reboot();
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    task automatic live(input logic [7:0] lv, input logic [15:0] rt,
                        input logic rn);
        logic [7:0] seen;
        seen = {watchdog_postscale_sel, powerup_delay_enable_n,
                brownout_reset_enable, brownout_threshold_select};
        `CHK("fields", lv, seen)
        `CHK("ratio", rt, watchdog_postscale_ratio)
        `CHK("run", rn, watchdog_run)
    endtask
    initial begin
        logic [31:0] q;
        logic        e;
        err_total = 0;
        comparisons = 0;
        presetn = 1'h0;
        por_n = 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        por_n <= 1'h1;
        repeat (2) @(posedge pclk);
        #1;
        live(8'hFF, 16'h8000, 1'h1);
        rdchk("low byte", A_SUP, 32'h0F);
        rdchk("high byte", A_WDG, 32'h1F);
        for (int i = 0; i < 16; i++) begin
            bus(1'h1, A_CTL, 32'h2, q, e);
            bus(1'h1, A_SUP, {24'hFFFFFF, rows[i].lo}, q, e);
            bus(1'h1, A_WDG, {24'hFFFFFF, rows[i].hi}, q, e);
            rdchk("low byte", A_SUP, {28'h0, rows[i].lo[3:0]});
            rdchk("high byte", A_WDG, {27'h0, rows[i].hi[4:0]});
            reboot();
            live(rows[i].live, rows[i].ratio, rows[i].run);
        end
        // new cell contents must not leak into live settings before reset
        bus(1'h1, A_SUP, 32'h0, q, e);
        repeat (3) @(posedge pclk);
        #1;
        live(8'h0F, 16'h0001, 1'h1);
        bus(1'h1, A_SUP, 32'hFF, q, e);
        rdchk("low byte", A_SUP, 32'h0);
        bus(1'h1, A_WDG, 32'hFE, q, e);
        reboot();
        live(8'h00, 16'h0001, 1'h0);
        bus(1'h1, A_CTL, 32'h1, q, e);
        repeat (2) @(posedge pclk);
        #1;
        `CHK("soft run", 1'h1, watchdog_run)
        rdchk("control", A_CTL, 32'h1);
        rdchk("status", A_STS, 32'hE00);
        bus(1'h1, A_CTL, 32'h0, q, e);
        repeat (2) @(posedge pclk);
        #1;
        `CHK("soft stop", 1'h0, watchdog_run)
        bus(1'h0, A_WDG + 32'h4, 32'h0, q, e);
        `CHK("unmapped error", 1'h1, e)
        `CHK("unmapped data", 32'h0, q)
        bus(1'h0, A_SUP + 32'h2, 32'h0, q, e);
        `CHK("misaligned error", 1'h1, e)
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
